/* File: rtl/adc_regs_pkg.sv */
// adc_regs_pkg: offsets, reset values, field positions and channel codes
// assumes: byte-wide register port, 8-bit offsets
`default_nettype none
package adc_regs_pkg;
  localparam logic [7:0] OFS_CHARGE_CURRENT_HIGH = 8'h46;
  localparam logic [7:0] OFS_CHARGE_CURRENT_LOW = 8'h47;
  localparam logic [7:0] OFS_AUX_INPUT_HIGH = 8'h48;
  localparam logic [7:0] OFS_AUX_INPUT_LOW = 8'h49;
  localparam logic [7:0] OFS_INPUT_VOLTAGE_HIGH = 8'h4A;
  localparam logic [7:0] OFS_INPUT_VOLTAGE_LOW = 8'h4B;
  localparam logic [7:0] OFS_SYSTEM_RAIL_HIGH = 8'h4C;
  localparam logic [7:0] OFS_SYSTEM_RAIL_LOW = 8'h4D;
  localparam logic [7:0] OFS_INPUT_CURRENT_HIGH = 8'h4E;
  localparam logic [7:0] OFS_INPUT_CURRENT_LOW = 8'h4F;
  localparam logic [7:0] OFS_ALARM_ONE_HIGH = 8'h52;
  localparam logic [7:0] OFS_ALARM_ONE_LOW = 8'h53;
  localparam logic [7:0] OFS_ALARM_TWO_HIGH = 8'h54;
  // control register: trigger, channel select, alarm flag
  localparam logic [7:0] OFS_ADC_CONTROL = 8'h40;
  localparam logic [7:0] RST_ALARM_ONE_HIGH = 8'h23;
  localparam logic [7:0] RST_ALARM_ONE_LOW = 8'h20;
  localparam logic [7:0] RST_ALARM_TWO_HIGH = 8'h38;
  localparam logic [7:0] RST_RESULT = 8'h00;
  localparam logic [2:0] RST_CHANNEL_SELECT = 3'h2;
  localparam int POS_POLARITY = 3;
  localparam int POS_TRIGGER = 5;
  localparam int POS_ALARM_FLAG = 7;
  localparam logic [2:0] CH_DISABLED = 3'h0;
  localparam logic [2:0] CH_AUX_INPUT = 3'h1;
  localparam logic [2:0] CH_THERMISTOR = 3'h2;
  localparam logic [2:0] CH_BATTERY = 3'h3;
  localparam logic [2:0] CH_CHARGE_CURRENT = 3'h4;
  localparam logic [2:0] CH_INPUT_VOLTAGE = 3'h5;
  localparam logic [2:0] CH_SYSTEM_RAIL = 3'h6;
  localparam logic [2:0] CH_INPUT_CURRENT = 3'h7;
endpackage
`default_nettype wire

/* File: rtl/threshold_compare.sv */
// threshold_compare: one-cycle alarm decision for a 12-bit threshold
// assumes: inputs stable in the cycle that sample is high
`default_nettype none
module threshold_compare #(
  parameter int WIDTH = 12
) (
  input wire logic [WIDTH-1:0] value,
  input wire logic [WIDTH-1:0] threshold,
  input wire logic above,
  input wire logic sample,
  output logic hit
);
  always_comb begin
    hit = sample & (above ? (value > threshold) : (value < threshold));
  end
endmodule
`default_nettype wire

/* File: rtl/result_capture.sv */
// result_capture: latches a 16-bit result when its channel completes
// assumes: single clock, asynchronous active-low reset
`default_nettype none
module result_capture #(
  parameter logic [2:0] CHANNEL = 3'h0
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic done,
  input wire logic [2:0] done_channel,
  input wire logic [15:0] done_data,
  input wire logic wr_high,
  input wire logic wr_low,
  input wire logic [7:0] wr_data,
  output logic [15:0] result
);
  typedef struct packed {
    logic [15:0] result;
  } state_s;
  state_s cur;
  state_s next_cur;
  always_comb begin
    next_cur = cur;
    if (wr_high) begin
      next_cur.result[15:8] = wr_data;
    end
    if (wr_low) begin
      next_cur.result[7:0] = wr_data;
    end
    if (done && done_channel == CHANNEL) begin
      next_cur.result = done_data;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end
  assign result = cur.result;
endmodule
`default_nettype wire

/* File: rtl/adc_result_and_alarm_regs.sv */
// adc_result_and_alarm_regs: result bytes, comparator 1 alarm, thresholds
// assumes: byte register port from the serial slave, converter core outside
//Contract
//- charge current low byte at 0x47
//- aux input result at 0x48/0x49
//- input voltage result at 0x4A/0x4B
//- system rail result at 0x4C/0x4D
//- input current result at 0x4E/0x4F
//- threshold one from 0x52 and 0x53[7:4]
//- threshold one resets to 0x23 and 0010
//- polarity 0 alarms below threshold
//- polarity 1 alarms above threshold
//- threshold two high at 0x54, reset 0x38
//- three-bit channel code selects comparator input
//- trigger self-clears when conversion completes
`default_nettype none
module adc_result_and_alarm_regs (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic conv_done,
  input wire logic [2:0] conv_channel,
  input wire logic [15:0] conv_data,
  input wire logic conv_busy,
  output logic manual_conversion_trigger,
  output logic alarm_one_irq,
  output logic alarm_one_flag
);
  typedef enum logic [1:0] {
    IDLE,
    WAIT_DONE
  } conv_e;
  typedef struct packed {
    logic [7:0] alarm_one_threshold_high;
    logic [7:0] alarm_one_threshold_low;
    logic [7:0] alarm_two_threshold_high;
    logic [2:0] alarm_one_channel_select;
    logic trigger;
    logic flag;
    logic irq;
    logic [7:0] rdata;
    conv_e conv;
  } state_s;
  state_s cur;
  state_s next_cur;
  logic [15:0] charge_current_result;
  logic [15:0] aux_input_result;
  logic [15:0] input_voltage_result;
  logic [15:0] system_rail_result;
  logic [15:0] input_current_result;
  logic [15:0] battery_result;
  logic [15:0] thermistor_result;
  logic [11:0] alarm_one_threshold;
  logic [11:0] done_value;
  logic sample;
  logic hit;
  logic wr_en;
  logic trig_req;

  assign wr_en = reg_wr;
  assign trig_req = wr_en && reg_addr == adc_regs_pkg::OFS_ADC_CONTROL &&
                    reg_wdata[adc_regs_pkg::POS_TRIGGER];

  // result registers per channel
  result_capture #(.CHANNEL(adc_regs_pkg::CH_CHARGE_CURRENT)) u_charge (
    .clk(clk),
    .arst_n(arst_n),
    .done(conv_done),
    .done_channel(conv_channel),
    .done_data(conv_data),
    .wr_high(wr_en && reg_addr == adc_regs_pkg::OFS_CHARGE_CURRENT_HIGH),
    .wr_low(wr_en && reg_addr == adc_regs_pkg::OFS_CHARGE_CURRENT_LOW),
    .wr_data(reg_wdata),
    .result(charge_current_result)
  );
  result_capture #(.CHANNEL(adc_regs_pkg::CH_AUX_INPUT)) u_aux (
    .clk(clk),
    .arst_n(arst_n),
    .done(conv_done),
    .done_channel(conv_channel),
    .done_data(conv_data),
    .wr_high(wr_en && reg_addr == adc_regs_pkg::OFS_AUX_INPUT_HIGH),
    .wr_low(wr_en && reg_addr == adc_regs_pkg::OFS_AUX_INPUT_LOW),
    .wr_data(reg_wdata),
    .result(aux_input_result)
  );
  result_capture #(.CHANNEL(adc_regs_pkg::CH_INPUT_VOLTAGE)) u_vin (
    .clk(clk),
    .arst_n(arst_n),
    .done(conv_done),
    .done_channel(conv_channel),
    .done_data(conv_data),
    .wr_high(wr_en && reg_addr == adc_regs_pkg::OFS_INPUT_VOLTAGE_HIGH),
    .wr_low(wr_en && reg_addr == adc_regs_pkg::OFS_INPUT_VOLTAGE_LOW),
    .wr_data(reg_wdata),
    .result(input_voltage_result)
  );
  result_capture #(.CHANNEL(adc_regs_pkg::CH_SYSTEM_RAIL)) u_rail (
    .clk(clk),
    .arst_n(arst_n),
    .done(conv_done),
    .done_channel(conv_channel),
    .done_data(conv_data),
    .wr_high(wr_en && reg_addr == adc_regs_pkg::OFS_SYSTEM_RAIL_HIGH),
    .wr_low(wr_en && reg_addr == adc_regs_pkg::OFS_SYSTEM_RAIL_LOW),
    .wr_data(reg_wdata),
    .result(system_rail_result)
  );
  result_capture #(.CHANNEL(adc_regs_pkg::CH_INPUT_CURRENT)) u_iin (
    .clk(clk),
    .arst_n(arst_n),
    .done(conv_done),
    .done_channel(conv_channel),
    .done_data(conv_data),
    .wr_high(wr_en && reg_addr == adc_regs_pkg::OFS_INPUT_CURRENT_HIGH),
    .wr_low(wr_en && reg_addr == adc_regs_pkg::OFS_INPUT_CURRENT_LOW),
    .wr_data(reg_wdata),
    .result(input_current_result)
  );

  // battery and thermistor only feed the comparator, no register here
  assign battery_result = (conv_channel == adc_regs_pkg::CH_BATTERY) ? conv_data : 16'h0000;
  assign thermistor_result =
    (conv_channel == adc_regs_pkg::CH_THERMISTOR) ? conv_data : 16'h0000;

  assign alarm_one_threshold = {cur.alarm_one_threshold_high,
                                cur.alarm_one_threshold_low[7:4]};

  // comparator input: selected channel, fresh conversion only
  always_comb begin
    done_value = 12'h000;
    sample = 1'b0;
    if (conv_done && conv_channel == cur.alarm_one_channel_select) begin
      sample = 1'b1;
      case (cur.alarm_one_channel_select)
        adc_regs_pkg::CH_DISABLED: sample = 1'b0;
        adc_regs_pkg::CH_AUX_INPUT: done_value = conv_data[15:4];
        adc_regs_pkg::CH_THERMISTOR: done_value = thermistor_result[15:4];
        adc_regs_pkg::CH_BATTERY: done_value = battery_result[15:4];
        adc_regs_pkg::CH_CHARGE_CURRENT: done_value = conv_data[15:4];
        adc_regs_pkg::CH_INPUT_VOLTAGE: done_value = conv_data[15:4];
        adc_regs_pkg::CH_SYSTEM_RAIL: done_value = conv_data[15:4];
        adc_regs_pkg::CH_INPUT_CURRENT: done_value = conv_data[15:4];
        default: sample = 1'b0;
      endcase
    end
  end

  threshold_compare #(.WIDTH(12)) u_cmp (
    .value(done_value),
    .threshold(alarm_one_threshold),
    .above(cur.alarm_one_threshold_low[adc_regs_pkg::POS_POLARITY]),
    .sample(sample),
    .hit(hit)
  );

  always_comb begin
    next_cur = cur;
    next_cur.irq = 1'b0;
    // register writes
    if (wr_en) begin
      case (reg_addr)
        adc_regs_pkg::OFS_ALARM_ONE_HIGH: next_cur.alarm_one_threshold_high = reg_wdata;
        adc_regs_pkg::OFS_ALARM_ONE_LOW: next_cur.alarm_one_threshold_low = reg_wdata;
        adc_regs_pkg::OFS_ALARM_TWO_HIGH: next_cur.alarm_two_threshold_high = reg_wdata;
        adc_regs_pkg::OFS_ADC_CONTROL: begin
          next_cur.alarm_one_channel_select = reg_wdata[2:0];
          if (reg_wdata[adc_regs_pkg::POS_TRIGGER]) begin
            next_cur.trigger = 1'b1;
          end
          if (!reg_wdata[adc_regs_pkg::POS_ALARM_FLAG]) begin
            next_cur.flag = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // conversion tracking
    case (cur.conv)
      IDLE: begin
        if (next_cur.trigger) begin
          next_cur.conv = WAIT_DONE;
        end
      end
      WAIT_DONE: begin
        if (conv_done && !conv_busy) begin
          // a start written in the ending cycle is kept, not lost
          next_cur.trigger = trig_req;
          next_cur.conv = trig_req ? WAIT_DONE : IDLE;
        end
      end
      default: next_cur.conv = IDLE;
    endcase
    // alarm set wins over clear
    if (hit) begin
      next_cur.flag = 1'b1;
      next_cur.irq = 1'b1;
    end
    // read data
    next_cur.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        adc_regs_pkg::OFS_CHARGE_CURRENT_HIGH: next_cur.rdata = charge_current_result[15:8];
        adc_regs_pkg::OFS_CHARGE_CURRENT_LOW: next_cur.rdata = charge_current_result[7:0];
        adc_regs_pkg::OFS_AUX_INPUT_HIGH: next_cur.rdata = aux_input_result[15:8];
        adc_regs_pkg::OFS_AUX_INPUT_LOW: next_cur.rdata = aux_input_result[7:0];
        adc_regs_pkg::OFS_INPUT_VOLTAGE_HIGH: next_cur.rdata = input_voltage_result[15:8];
        adc_regs_pkg::OFS_INPUT_VOLTAGE_LOW: next_cur.rdata = input_voltage_result[7:0];
        adc_regs_pkg::OFS_SYSTEM_RAIL_HIGH: next_cur.rdata = system_rail_result[15:8];
        adc_regs_pkg::OFS_SYSTEM_RAIL_LOW: next_cur.rdata = system_rail_result[7:0];
        adc_regs_pkg::OFS_INPUT_CURRENT_HIGH: next_cur.rdata = input_current_result[15:8];
        adc_regs_pkg::OFS_INPUT_CURRENT_LOW: next_cur.rdata = input_current_result[7:0];
        adc_regs_pkg::OFS_ALARM_ONE_HIGH: next_cur.rdata = cur.alarm_one_threshold_high;
        adc_regs_pkg::OFS_ALARM_ONE_LOW: next_cur.rdata = cur.alarm_one_threshold_low;
        adc_regs_pkg::OFS_ALARM_TWO_HIGH: next_cur.rdata = cur.alarm_two_threshold_high;
        adc_regs_pkg::OFS_ADC_CONTROL: begin
          next_cur.rdata = {cur.flag, 1'b0, cur.trigger, 2'b00, cur.alarm_one_channel_select};
        end
        default: next_cur.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cur.alarm_one_threshold_high <= adc_regs_pkg::RST_ALARM_ONE_HIGH;
      cur.alarm_one_threshold_low <= adc_regs_pkg::RST_ALARM_ONE_LOW;
      cur.alarm_two_threshold_high <= adc_regs_pkg::RST_ALARM_TWO_HIGH;
      cur.alarm_one_channel_select <= adc_regs_pkg::RST_CHANNEL_SELECT;
      cur.trigger <= 1'b0;
      cur.flag <= 1'b0;
      cur.irq <= 1'b0;
      cur.rdata <= adc_regs_pkg::RST_RESULT;
      cur.conv <= IDLE;
    end else begin
      cur <= next_cur;
    end
  end

  assign reg_rdata = cur.rdata;
  assign manual_conversion_trigger = cur.trigger;
  assign alarm_one_irq = cur.irq;
  assign alarm_one_flag = cur.flag;
endmodule
`default_nettype wire

/* File: tb/adc_converter_model.sv */
// adc_converter_model: converter core answering with result pulses
// assumes: the bench calls convert just after a rising clock edge
`default_nettype none
module adc_converter_model (
  input wire logic clk,
  output logic conv_done,
  output logic [2:0] conv_channel,
  output logic [15:0] conv_data,
  output logic conv_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    conv_done = 1'b0;
    conv_busy = 1'b0;
    conv_channel = 3'h0;
    conv_data = 16'h0000;
  end
  // busy for slow cycles, then a one-cycle done with the result
  task automatic convert(input logic [2:0] ch, input logic [15:0] d, input int slow);
    @(posedge clk) #1;
    if (slow > 0) begin
      conv_busy = 1'b1;
      repeat (slow) @(posedge clk) #1;
      conv_busy = 1'b0;
    end
    conv_done = 1'b1;
    conv_channel = ch;
    conv_data = d;
    @(posedge clk) #1;
    conv_done = 1'b0;
    // stale qualifiers are scrambled, never left looking valid
    conv_channel = ~ch;
    conv_data = ~d;
  endtask
endmodule
`default_nettype wire

/* File: tb/adc_result_and_alarm_regs_props.sv */
// adc_regs_checker: port assertions for the result and alarm registers
// assumes: bound to adc_result_and_alarm_regs, one clock domain
`default_nettype none
module adc_regs_checker (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic conv_done,
  input wire logic conv_busy,
  input wire logic manual_conversion_trigger,
  input wire logic alarm_one_irq,
  input wire logic alarm_one_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  sequence trig_done_s;
    manual_conversion_trigger && conv_done && !conv_busy;
  endsequence
  sequence trig_wr_s;
    reg_wr && reg_addr == adc_regs_pkg::OFS_ADC_CONTROL && reg_wdata[5];
  endsequence
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  chk_irq_pulse: assert property (alarm_one_irq && !conv_done |=> !alarm_one_irq)
    else $error("alarm pulse longer than one cycle");
  chk_irq_flag: assert property (alarm_one_irq |-> alarm_one_flag)
    else $error("alarm pulse without flag");
  chk_irq_cause: assert property (alarm_one_irq |-> $past(conv_done))
    else $error("alarm pulse without a finished conversion");
  chk_flag_rise: assert property ($rose(alarm_one_flag) |-> alarm_one_irq)
    else $error("flag rose without alarm pulse");
  chk_flag_sticky: assert property (alarm_one_flag && !reg_wr |=> alarm_one_flag)
    else $error("flag dropped without a write");
  chk_trig_clear: assert property (trig_done_s ##0 !reg_wr |=> !manual_conversion_trigger)
    else $error("trigger not cleared after conversion");
  chk_trig_set: assert property (trig_wr_s |=> manual_conversion_trigger)
    else $error("trigger not set by control write");
  chk_trig_hold: assert property (manual_conversion_trigger && !conv_done && !reg_wr
    |=> manual_conversion_trigger)
    else $error("trigger dropped before conversion end");
  chk_trig_rise: assert property ($rose(manual_conversion_trigger) |-> $past(reg_wr))
    else $error("trigger rose without a write");
endmodule
bind adc_result_and_alarm_regs adc_regs_checker chk (.clk, .arst_n, .reg_wr, .reg_rd, .reg_addr,
  .reg_wdata, .reg_rdata, .conv_done, .conv_busy, .manual_conversion_trigger, .alarm_one_irq,
  .alarm_one_flag);
`default_nettype wire

/* File: tb/adc_result_and_alarm_regs_tb.sv */
// adc_result_and_alarm_regs_tb: directed register and alarm scenarios
// assumes: converter model drives the conversion inputs
`default_nettype none
module adc_result_and_alarm_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, arst_n, reg_wr, reg_rd, conv_done, conv_busy;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [2:0] conv_channel;
  logic [15:0] conv_data;
  logic manual_conversion_trigger, alarm_one_irq, alarm_one_flag;
  int err_total = 0;
  int total_checks = 0;
  int cycles = 0;
  adc_result_and_alarm_regs DUT (.clk, .arst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .conv_done, .conv_channel, .conv_data, .conv_busy, .manual_conversion_trigger,
    .alarm_one_irq, .alarm_one_flag);
  adc_converter_model conv (.clk, .conv_done, .conv_channel, .conv_data, .conv_busy);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      test_done();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk) #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clk) #1;
    reg_rd = 1'b0;
    check({8'h00, reg_rdata}, {8'h00, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk) #1;
    reg_wr = 1'b0;
  endtask
  task automatic t_reset();
    rd(adc_regs_pkg::OFS_ALARM_ONE_HIGH, 8'h23);
    rd(adc_regs_pkg::OFS_ALARM_ONE_LOW, 8'h20);
    rd(adc_regs_pkg::OFS_ALARM_TWO_HIGH, 8'h38);
    rd(8'h50, 8'h00);
    rd(adc_regs_pkg::OFS_ADC_CONTROL, 8'h02);
    conv.convert(3'h2, 16'h0000, 0);
    check({14'h0000, alarm_one_irq, alarm_one_flag}, 16'h0003);
  endtask
  task automatic t_results();
    logic [2:0] ch [5] = '{3'h4, 3'h1, 3'h5, 3'h6, 3'h7};
    logic [7:0] ofs [5] = '{8'h46, 8'h48, 8'h4A, 8'h4C, 8'h4E};
    logic [15:0] d;
    wr(adc_regs_pkg::OFS_ADC_CONTROL, {5'h00, adc_regs_pkg::CH_DISABLED});
    for (int i = 0; i < 5; i++) begin
      d = 16'hA55A ^ {4{i[3:0]}};
      conv.convert(ch[i], d, 1);
      rd(ofs[i], d[15:8]);
      rd(ofs[i] + 8'h01, d[7:0]);
    end
    conv.convert(3'h0, 16'h0000, 0);
    check({14'h0000, alarm_one_irq, alarm_one_flag}, 16'h0000);
  endtask
  task automatic t_below();
    wr(adc_regs_pkg::OFS_ADC_CONTROL, {5'h00, adc_regs_pkg::CH_AUX_INPUT});
    conv.convert(3'h1, 16'h232F, 0);
    check({14'h0000, alarm_one_irq, alarm_one_flag}, 16'h0000);
    conv.convert(3'h1, 16'h2310, 0);
    check({14'h0000, alarm_one_irq, alarm_one_flag}, 16'h0003);
  endtask
  task automatic t_above();
    wr(adc_regs_pkg::OFS_ALARM_ONE_HIGH, 8'h80);
    wr(adc_regs_pkg::OFS_ALARM_ONE_LOW, 8'h58);
    rd(adc_regs_pkg::OFS_ALARM_ONE_LOW, 8'h58);
    wr(adc_regs_pkg::OFS_ADC_CONTROL, {5'h00, adc_regs_pkg::CH_INPUT_VOLTAGE});
    conv.convert(3'h5, 16'h805F, 0);
    conv.convert(3'h1, 16'hFFF0, 0);
    check({14'h0000, alarm_one_irq, alarm_one_flag}, 16'h0000);
    conv.convert(3'h5, 16'h8060, 0);
    check({14'h0000, alarm_one_irq, alarm_one_flag}, 16'h0003);
  endtask
  task automatic t_trigger();
    wr(adc_regs_pkg::OFS_ADC_CONTROL, 8'h27);
    check({15'h0000, manual_conversion_trigger}, 16'h0001);
    conv.convert(3'h7, 16'h4321, 4);
    check({15'h0000, manual_conversion_trigger}, 16'h0000);
    check({14'h0000, alarm_one_irq, alarm_one_flag}, 16'h0000);
    rd(adc_regs_pkg::OFS_INPUT_CURRENT_LOW, 8'h21);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    arst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    repeat (8) @(posedge clk);
    #1 arst_n = 1'b1;
    t_reset();
    t_results();
    t_below();
    t_above();
    t_trigger();
    test_done();
  end
endmodule
`default_nettype wire
